// ### shared/aasd_defs.svh
// Constants of the add/subtract datapath: widths, limits, codes.
// Assumes inclusion by bare name from the package and from the rtl files.
`ifndef AASD_DEFS_SVH
`define AASD_DEFS_SVH
`define AASD_W          8
`define AASD_IDX_W      5
`define AASD_IO_W       6
`define AASD_BIT_W      3
`define AASD_IO_FIRST   6'h00
`define AASD_IO_LAST    6'h1F
`define AASD_ZERO8      8'h00
`define AASD_ONE8       8'h01
`define AASD_MSB        7
`define AASD_PAIR_LSB   1'h0
`define AASD_PAIR_MSB   1'h1
`define AASD_FLAGS_RST  6'h00
`endif

// ### shared/aasd_pkg.sv
// Types shared by the add/subtract datapath and its testbench.
// Assumes aasd_defs.svh is on the include path.
`include "aasd_defs.svh"
package aasd_pkg;
    typedef enum logic [2:0] {
        AASD_SUM_TWO_REGS        = 3'h0,
        AASD_SUM_WITH_CARRY      = 3'h1,
        AASD_WORD_IMMEDIATE_PLUS = 3'h2,
        AASD_DIFFERENCE_TWO_REGS = 3'h3,
        AASD_DIFFERENCE_IMM      = 3'h4,
        AASD_IO_BIT_CLEAR_OP     = 3'h5,
        AASD_IO_BIT_SET_OP       = 3'h6,
        AASD_NOP                 = 3'h7
    } aasd_op_e;

    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } aasd_flags_s;

    typedef struct packed {
        aasd_op_e                  op;
        logic [`AASD_IDX_W-1:0]    dst_idx;
        logic [`AASD_W-1:0]        dst_val;
        logic [`AASD_W-1:0]        src_val;
        logic [`AASD_W-1:0]        hi_val;
        logic [`AASD_IO_W-1:0]     io_addr;
        logic [`AASD_BIT_W-1:0]    io_bit;
        logic [`AASD_W-1:0]        io_rdata;
    } aasd_req_s;
endpackage : aasd_pkg

// ### rtl/aasd_add8.sv
// Eight-bit adder slice with carry out of bits 3 and 7 and overflow.
// Assumes subtraction is fed as a plus inverted b plus one.
`timescale 1ns/1ps
`include "aasd_defs.svh"
module aasd_add8 (
    // Operands
    input  wire logic [`AASD_W-1:0] i_a,
    input  wire logic [`AASD_W-1:0] i_b,
    input  wire logic               i_cin,
    // Results
    output logic      [`AASD_W-1:0] o_sum,
    output logic                    o_c7,
    output logic                    o_c3,
    output logic                    o_v
);
    logic [4:0] low;

    assign low           = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
    assign o_c3          = low[4];
    assign {o_c7, o_sum} = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
    assign o_v           = (i_a[`AASD_MSB] & i_b[`AASD_MSB] & ~o_sum[`AASD_MSB])
                         | (~i_a[`AASD_MSB] & ~i_b[`AASD_MSB] & o_sum[`AASD_MSB]);
endmodule : aasd_add8

// ### rtl/aasd_datapath.sv
// Add/subtract datapath with single-bit I/O set and clear.
// Assumes the caller presents operands read from the register file and I/O space
// together with a one-cycle start, and commits the registered write outputs.
//
// Summary of operation
// - Sum and sum-with-carry write dst plus src (plus C) into dst, update Z C N V H, in one clock.
// - Word immediate plus adds K to the register pair hi:lo, writes both bytes, updates Z C N V S, in two clocks.
// - Both difference operations write dst minus src or constant into dst, update Z C N V H, in one clock.
// - I/O bit set and clear are taken only for I/O addresses 00 to 1F.
// - I/O bit set and clear rewrite the whole register read, so a write-one-to-clear flag read as set is cleared.
`timescale 1ns/1ps
`include "aasd_defs.svh"
module aasd_datapath (
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    // Request
    input  wire logic                   i_start,
    input  aasd_pkg::aasd_req_s         i_req,
    // Register file write
    output logic                        o_wr_en,
    output logic [`AASD_IDX_W-1:0]      o_wr_idx,
    output logic [`AASD_W-1:0]          o_wr_data,
    // I/O write
    output logic                        o_io_we,
    output logic [`AASD_IO_W-1:0]       o_io_addr,
    output logic [`AASD_W-1:0]          o_io_wdata,
    // Status
    output aasd_pkg::aasd_flags_s       o_status,
    output logic                        o_busy,
    output logic                        o_done,
    output logic                        o_refused
);
    //**********************************************************
    // Decode and operand select
    //**********************************************************
    typedef enum logic {
        AASD_IDLE    = 1'b0,
        AASD_WORD_HI = 1'b1
    } aasd_state_e;

    aasd_state_e        state;
    logic [`AASD_W-1:0] hi_save;
    logic               lo_carry;
    logic               take;
    logic               is_sub;
    logic               io_ok;
    logic [`AASD_W-1:0] add_a;
    logic [`AASD_W-1:0] add_b;
    logic               add_cin;
    logic [`AASD_W-1:0] sum;
    logic               c7;
    logic               c3;
    logic               ovf;
    logic [`AASD_W-1:0] bit_mask;

    function automatic logic is_io_op(input aasd_pkg::aasd_op_e op);
        is_io_op = (op == aasd_pkg::AASD_IO_BIT_CLEAR_OP) || (op == aasd_pkg::AASD_IO_BIT_SET_OP);
    endfunction : is_io_op

    function automatic logic is_byte_op(input aasd_pkg::aasd_op_e op);
        is_byte_op = (op == aasd_pkg::AASD_SUM_TWO_REGS) || (op == aasd_pkg::AASD_SUM_WITH_CARRY)
                   || (op == aasd_pkg::AASD_DIFFERENCE_TWO_REGS) || (op == aasd_pkg::AASD_DIFFERENCE_IMM);
    endfunction : is_byte_op

    // A start during the high-byte cycle is dropped; o_busy warns the caller
    assign take     = i_start && (state == AASD_IDLE);
    assign is_sub   = (i_req.op == aasd_pkg::AASD_DIFFERENCE_TWO_REGS) || (i_req.op == aasd_pkg::AASD_DIFFERENCE_IMM);
    assign io_ok    = i_req.io_addr <= `AASD_IO_LAST;
    assign bit_mask = `AASD_ONE8 << i_req.io_bit;

    always_comb begin
        if (state == AASD_WORD_HI) begin
            add_a   = hi_save;
            add_b   = `AASD_ZERO8;
            add_cin = lo_carry;
        end else begin
            add_a   = i_req.dst_val;
            add_b   = is_sub ? ~i_req.src_val : i_req.src_val;
            add_cin = is_sub || ((i_req.op == aasd_pkg::AASD_SUM_WITH_CARRY) && o_status.c);
        end
    end

    aasd_add8 u_add (
        .i_a   (add_a),
        .i_b   (add_b),
        .i_cin (add_cin),
        .o_sum (sum),
        .o_c7  (c7),
        .o_c3  (c3),
        .o_v   (ovf)
    );

    //**********************************************************
    // Sequencing
    //**********************************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state    <= AASD_IDLE;
            hi_save  <= `AASD_ZERO8;
            lo_carry <= 1'b0;
            o_busy   <= 1'b0;
        end else if (take && (i_req.op == aasd_pkg::AASD_WORD_IMMEDIATE_PLUS)) begin
            state    <= AASD_WORD_HI;
            hi_save  <= i_req.hi_val;
            lo_carry <= c7;
            o_busy   <= 1'b1;
        end else begin
            state    <= AASD_IDLE;
            o_busy   <= 1'b0;
        end
    end

    //**********************************************************
    // Register file write-back
    //**********************************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_wr_en   <= 1'b0;
            o_wr_idx  <= {`AASD_IDX_W{1'b0}};
            o_wr_data <= `AASD_ZERO8;
            o_done    <= 1'b0;
        end else if (state == AASD_WORD_HI) begin
            o_wr_en   <= 1'b1;
            o_wr_idx  <= {o_wr_idx[`AASD_IDX_W-1:1], `AASD_PAIR_MSB};
            o_wr_data <= sum;
            o_done    <= 1'b1;
        end else if (take && (is_byte_op(i_req.op) || (i_req.op == aasd_pkg::AASD_WORD_IMMEDIATE_PLUS))) begin
            o_wr_en   <= 1'b1;
            o_wr_idx  <= (i_req.op == aasd_pkg::AASD_WORD_IMMEDIATE_PLUS)
                       ? {i_req.dst_idx[`AASD_IDX_W-1:1], `AASD_PAIR_LSB} : i_req.dst_idx;
            o_wr_data <= sum;
            o_done    <= (i_req.op != aasd_pkg::AASD_WORD_IMMEDIATE_PLUS);
        end else begin
            o_wr_en   <= 1'b0;
            o_done    <= take && is_io_op(i_req.op) && io_ok;
        end
    end

    //**********************************************************
    // Status flags
    //**********************************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_status <= `AASD_FLAGS_RST;
        end else if (state == AASD_WORD_HI) begin
            // Sixteen-bit view: zero needs both bytes, sign comes from the high byte
            o_status.z <= (sum == `AASD_ZERO8) && (o_wr_data == `AASD_ZERO8);
            o_status.n <= sum[`AASD_MSB];
            o_status.v <= ~hi_save[`AASD_MSB] & sum[`AASD_MSB];
            o_status.c <= hi_save[`AASD_MSB] & ~sum[`AASD_MSB];
            o_status.s <= sum[`AASD_MSB] ^ (~hi_save[`AASD_MSB] & sum[`AASD_MSB]);
        end else if (take && is_byte_op(i_req.op)) begin
            // Subtraction runs as a plus not b plus one, so carries invert into borrows
            o_status.c <= is_sub ? ~c7 : c7;
            o_status.h <= is_sub ? ~c3 : c3;
            o_status.n <= sum[`AASD_MSB];
            o_status.v <= ovf;
            o_status.z <= (sum == `AASD_ZERO8);
        end
    end

    //**********************************************************
    // Single-bit I/O set and clear
    //**********************************************************
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            o_io_we    <= 1'b0;
            o_io_addr  <= `AASD_IO_FIRST;
            o_io_wdata <= `AASD_ZERO8;
            o_refused  <= 1'b0;
        end else if (take && is_io_op(i_req.op)) begin
            o_io_we    <= io_ok;
            o_refused  <= !io_ok;
            o_io_addr  <= i_req.io_addr;
            // Whole value read is written back; set w1c flags therefore clear
            o_io_wdata <= (i_req.op == aasd_pkg::AASD_IO_BIT_SET_OP) ? (i_req.io_rdata | bit_mask)
                        : (i_req.io_rdata & ~bit_mask);
        end else begin
            o_io_we    <= 1'b0;
            o_refused  <= 1'b0;
        end
    end

    //**********************************************************
    // Checks
    //**********************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    logic [`AASD_W:0] add9;
    assign add9 = {1'b0, i_req.dst_val} + {1'b0, i_req.src_val};

    sequence word_begin;
        take && (i_req.op == aasd_pkg::AASD_WORD_IMMEDIATE_PLUS);
    endsequence
    sequence word_low_write;
        o_wr_en && !o_done && o_busy;
    endsequence
    sequence word_high_write;
        o_wr_en && o_done && !o_busy;
    endsequence

    sum_result_a: assert property (
        take && (i_req.op == aasd_pkg::AASD_SUM_TWO_REGS)
        |=> o_wr_en && o_done && (o_wr_data == $past(add9[`AASD_W-1:0])))
        else $error("sum result wrong");
    sum_carry_a: assert property (
        take && (i_req.op == aasd_pkg::AASD_SUM_TWO_REGS) |=> o_status.c == $past(add9[`AASD_W]))
        else $error("carry flag wrong");
    word_two_clk_a: assert property (
        word_begin |=> word_low_write ##1 word_high_write)
        else $error("word add not two clocks");
    diff_result_a: assert property (
        take && is_sub |=> o_wr_en && o_done
        && (o_wr_data == $past(i_req.dst_val) - $past(i_req.src_val))
        && (o_status.c == ($past(i_req.dst_val) < $past(i_req.src_val))))
        else $error("difference wrong");
    zero_flag_a: assert property (
        take && is_byte_op(i_req.op) |=> o_status.z == (o_wr_data == `AASD_ZERO8))
        else $error("zero flag wrong");
    io_range_a: assert property (
        take && is_io_op(i_req.op) && (i_req.io_addr > `AASD_IO_LAST) |=> o_refused && !o_io_we)
        else $error("io address out of range taken");
    io_rmw_a: assert property (
        take && (i_req.op == aasd_pkg::AASD_IO_BIT_SET_OP) && io_ok
        |=> o_io_we && (o_io_wdata == ($past(i_req.io_rdata) | $past(bit_mask))))
        else $error("io set lost other bits");
    io_clear_a: assert property (
        take && (i_req.op == aasd_pkg::AASD_IO_BIT_CLEAR_OP) && io_ok
        |=> o_io_we && (o_io_wdata == ($past(i_req.io_rdata) & ~$past(bit_mask))))
        else $error("io clear lost other bits");
endmodule : aasd_datapath

// ### testbench/aasd_regfile_model.sv
// Far-side model: general purpose register file and I/O space behind the datapath.
// Assumes writes arrive as the datapath's registered one-cycle pulses on i_core_clk.
`timescale 1ns/1ps
`include "aasd_defs.svh"
module aasd_regfile_model #(
    parameter logic [5:0] W1C_ADDR = 6'h0E,
    parameter logic [7:0] W1C_MASK = 8'h80
) (
    // Clock and reset
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset_n,
    // Writes from the datapath
    input  wire logic                   i_wr_en,
    input  wire logic [`AASD_IDX_W-1:0] i_wr_idx,
    input  wire logic [`AASD_W-1:0]     i_wr_data,
    input  wire logic                   i_io_we,
    input  wire logic [`AASD_IO_W-1:0]  i_io_addr,
    input  wire logic [`AASD_W-1:0]     i_io_wdata,
    // Read ports
    input  wire logic [`AASD_IDX_W-1:0] i_rd_idx,
    output logic      [`AASD_W-1:0]     o_rd_data,
    input  wire logic [`AASD_IO_W-1:0]  i_io_ra,
    output logic      [`AASD_W-1:0]     o_io_rdata
);
    logic [7:0] regs [32];
    logic [7:0] io   [64];

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            for (int k = 0; k < 64; k++) begin
                io[k] <= 8'h00;
            end
            // One status flag already raised and one plain bit set
            io[W1C_ADDR] <= 8'h81;
            for (int k = 0; k < 32; k++) begin
                regs[k] <= 8'h00;
            end
        end else begin
            if (i_wr_en) begin
                regs[i_wr_idx] <= i_wr_data;
            end
            // Flags clear on a written one, so a whole-register write-back clears raised flags
            if (i_io_we && i_io_addr == W1C_ADDR) begin
                // Flag bits survive only where a zero is written; plain bits take the written value
                io[i_io_addr] <= (io[i_io_addr] & W1C_MASK & ~i_io_wdata) | (i_io_wdata & ~W1C_MASK);
            end else if (i_io_we) begin
                io[i_io_addr] <= i_io_wdata;
            end
        end
    end

    assign o_rd_data  = regs[i_rd_idx];
    assign o_io_rdata = io[i_io_ra];
endmodule : aasd_regfile_model

// ### testbench/arith_add_sub_datapath_tb.sv
// Self-checking bench of the add/subtract datapath with its register file model.
// Assumes the designer's contract: results one edge after start, word op two edges.
`timescale 1ns/1ps
`include "aasd_defs.svh"
module arith_add_sub_datapath_tb;
    logic core_clk = 1'b0, reset_n = 1'b0, start = 1'b0;
    aasd_pkg::aasd_req_s req = '0;
    logic wr_en, io_we, busy, done, refused;
    logic [4:0] wr_idx, rd_idx = 5'h00;
    logic [5:0] io_addr, io_ra = 6'h0E;
    logic [7:0] wr_data, io_wdata, rd_data, io_rdata;
    aasd_pkg::aasd_flags_s status;
    int error_cnt = 0, n_tests = 0;

    aasd_datapath dut (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_start(start), .i_req(req),
        .o_wr_en(wr_en), .o_wr_idx(wr_idx), .o_wr_data(wr_data), .o_io_we(io_we), .o_io_addr(io_addr),
        .o_io_wdata(io_wdata), .o_status(status), .o_busy(busy), .o_done(done), .o_refused(refused));
    aasd_regfile_model far (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_wr_en(wr_en), .i_wr_idx(wr_idx),
        .i_wr_data(wr_data), .i_io_we(io_we), .i_io_addr(io_addr), .i_io_wdata(io_wdata),
        .i_rd_idx(rd_idx), .o_rd_data(rd_data), .i_io_ra(io_ra), .o_io_rdata(io_rdata));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // Wide enough for the I/O compares, which carry three pulse bits ahead of address and data
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // Reference sum: {result, flags h s v n z c}; subtraction is a plus inverted b plus one
    function automatic logic [13:0] ref8(input logic [7:0] a, input logic [7:0] b, input logic sub,
                                         input logic ci, input aasd_pkg::aasd_flags_s f);
        logic [7:0] bb;
        logic [8:0] r;
        logic [4:0] h;
        bb = sub ? ~b : b;
        r = {1'b0, a} + {1'b0, bb} + 9'(sub | ci);
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + 5'(sub | ci);
        return {r[7:0], h[4] ^ sub, f.s, (a[7] == bb[7]) && (r[7] != a[7]), r[7], r[7:0] == 8'h00, r[8] ^ sub};
    endfunction : ref8

    task automatic run(input aasd_pkg::aasd_op_e op, input logic [7:0] d, input logic [7:0] s,
                       input logic [7:0] h, input logic [5:0] a, input logic [2:0] b, input logic [7:0] rd);
        @(posedge core_clk);
        start <= 1'b1;
        req <= '{op, 5'h19, d, s, h, a, b, rd};
        @(posedge core_clk);
        start <= 1'b0;
        #1;
    endtask : run

    task automatic byte_op(input aasd_pkg::aasd_op_e op, input logic [7:0] d, input logic [7:0] s,
                           input logic sub, input logic ci);
        logic [13:0] e;
        e = ref8(d, s, sub, ci, status);
        run(op, d, s, 8'h00, 6'h00, 3'h0, 8'h00);
        chk({wr_en, done, busy, 5'(wr_idx), wr_data}, {3'b110, 5'h19, e[13:6]});
        chk(status, e[5:0]);
        rd_idx <= 5'h19;
        @(posedge core_clk);
        #1;
        chk({wr_en, done, rd_data}, {2'b00, e[13:6]});
        $display("Byte op %0d done", op);
    endtask : byte_op

    task automatic word_test();
        logic [5:0] f0;
        f0 = status;
        run(aasd_pkg::AASD_WORD_IMMEDIATE_PLUS, 8'hF0, 8'h10, 8'hFF, 6'h00, 3'h0, 8'h00);
        chk({wr_en, busy, done, 5'(wr_idx), wr_data}, {3'b110, 5'h18, 8'h00});
        @(posedge core_clk);
        #1;
        chk({wr_en, busy, done, 5'(wr_idx), wr_data}, {3'b101, 5'h19, 8'h00});
        chk(status, {f0[5], 5'b00011});
        run(aasd_pkg::AASD_WORD_IMMEDIATE_PLUS, 8'hFF, 8'h01, 8'h7F, 6'h00, 3'h0, 8'h00);
        @(posedge core_clk);
        #1;
        chk({wr_data, status}, {8'h80, f0[5], 5'b01100});
        $display("Word op done");
    endtask : word_test

    task automatic io_test();
        run(aasd_pkg::AASD_IO_BIT_CLEAR_OP, 8'h00, 8'h00, 8'h00, 6'h0E, 3'h0, io_rdata);
        chk({io_we, done, refused, 2'b00, io_addr, io_wdata}, {3'b110, 2'b00, 6'h0E, 8'h80});
        @(posedge core_clk);
        #1;
        chk(io_rdata, 8'h00);
        run(aasd_pkg::AASD_IO_BIT_SET_OP, 8'h00, 8'h00, 8'h00, 6'h1F, 3'h7, 8'h05);
        chk({io_we, done, refused, io_addr, io_wdata}, {3'b110, 6'h1F, 8'h85});
        run(aasd_pkg::AASD_IO_BIT_SET_OP, 8'h00, 8'h00, 8'h00, 6'h20, 3'h1, 8'h00);
        chk({io_we, done, refused}, 3'b001);
        $display("I/O ops done");
    endtask : io_test

    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        byte_op(aasd_pkg::AASD_SUM_TWO_REGS, 8'h7F, 8'h01, 1'b0, 1'b0);
        byte_op(aasd_pkg::AASD_SUM_TWO_REGS, 8'hF8, 8'h08, 1'b0, 1'b0);
        byte_op(aasd_pkg::AASD_SUM_WITH_CARRY, 8'h0E, 8'h01, 1'b0, status.c);
        byte_op(aasd_pkg::AASD_DIFFERENCE_TWO_REGS, 8'h10, 8'h01, 1'b1, 1'b0);
        byte_op(aasd_pkg::AASD_DIFFERENCE_IMM, 8'h80, 8'h01, 1'b1, 1'b0);
        byte_op(aasd_pkg::AASD_DIFFERENCE_IMM, 8'h05, 8'h05, 1'b1, 1'b0);
        word_test();
        io_test();
        finish_test();
    end
endmodule : arith_add_sub_datapath_tb
